/* rtl/crs_seed_poly_regs.sv */
// register set of the programmable checksum unit with its engine
// What this block does
// [RL1] a 32-bit seed register at offset 0x10 is fully writable and gives the start value of a new checksum.
// [RL2] the seed register reads all ones after reset and takes any value software writes.
// [RL3] a 32-bit polynomial register at offset 0x14 is read/write and its contents drive the computation.
// [RL4] the polynomial register holds 0x04c11db7 after reset.
// [RL5] software puts a narrower polynomial in the low bits of the polynomial register.
// [RL6] data sits at 0x00 (reset all ones), the 8-bit scratch byte at 0x04 and control at 0x08 (both reset zero).
// [RL7] writing one to control bit 0 loads the data register from the seed, and that bit clears itself.
// [RL8] control bits 4:3 pick a 32, 16, 8 or 7 bit polynomial.
// [RL9] control bits 6:5 leave input bit order alone or reverse it per byte, half-word or word.
// [RL10] with control bit 7 set the data register reads back bit-reversed.
// [RL11] reserved control bits read zero and ignore writes; all registers take plain aligned word accesses.
module crs_seed_poly_regs
    import crs_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out
);
    logic [DATA_W-1:0] data_ff;
    logic [DATA_W-1:0] nxt_data;
    logic [SCRATCH_W-1:0] scratch_ff;
    logic [CTRL_W-1:0] ctrl_ff;
    logic [DATA_W-1:0] seed_ff;
    logic [DATA_W-1:0] poly_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;

    crs_eng_if eng_bus();

    crs_engine u_engine (
        .eng(eng_bus)
    );

    // address decode
    wire sel_data = (addr_in == OFF_DATA);
    wire sel_scratch = (addr_in == OFF_SCRATCH);
    wire sel_ctrl = (addr_in == OFF_CTRL);
    wire sel_seed = (addr_in == OFF_SEED);
    wire sel_poly = (addr_in == OFF_POLY);

    wire wr_data = wr_in && sel_data;
    wire wr_scratch = wr_in && sel_scratch;
    wire wr_ctrl = wr_in && sel_ctrl;
    wire wr_seed = wr_in && sel_seed;
    wire wr_poly = wr_in && sel_poly;

    // the reset bit is never stored, so it always reads back as zero
    wire reset_req = wr_ctrl && wdata_in[CTRL_RESET_BIT]; // RL7
    wire [CTRL_W-1:0] ctrl_wfield = wdata_in[CTRL_HI:CTRL_LO]; // RL11

    wire [1:0] size_sel = ctrl_ff[CTRL_SIZE_LSB-CTRL_LO +: 2]; // RL8
    wire [1:0] rev_in_sel = ctrl_ff[CTRL_REVIN_LSB-CTRL_LO +: 2]; // RL9
    wire rev_out = ctrl_ff[CTRL_REVOUT_BIT-CTRL_LO]; // RL10
    wire [1:0] size_wfield = ctrl_wfield[CTRL_SIZE_LSB-CTRL_LO +: 2];

    // engine hookup; the engine sees the settings held before this write
    assign eng_bus.crc_cur = data_ff;
    assign eng_bus.din = wdata_in;
    assign eng_bus.poly = poly_ff; // RL3
    assign eng_bus.size_sel = size_sel;
    assign eng_bus.rev_in_sel = rev_in_sel;

    // a reset writes the width field in the same word, so the seed is cut to the new width
    assign nxt_data = reset_req ? (seed_ff & crs_width_mask(size_wfield)) : // RL7
                      wr_data ? eng_bus.crc_nxt : data_ff; // RL3

    wire [DATA_W-1:0] data_view = rev_out ? crs_bit_rev32(data_ff) : data_ff; // RL10
    wire [DATA_W-1:0] ctrl_view = {{(DATA_W-CTRL_HI-1){1'b0}}, ctrl_ff, {CTRL_LO{1'b0}}}; // RL11
    wire [DATA_W-1:0] scratch_view = {{(DATA_W-SCRATCH_W){1'b0}}, scratch_ff}; // RL6

    // unmapped offsets read as zero; data only stand in the cycle after the read strobe
    wire [DATA_W-1:0] rd_mux = sel_data ? data_view :
                               sel_scratch ? scratch_view :
                               sel_ctrl ? ctrl_view :
                               sel_seed ? seed_ff :
                               sel_poly ? poly_ff : '0;
    assign nxt_rdata = rd_in ? rd_mux : '0;

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            data_ff <= RST_DATA; // RL6
            scratch_ff <= RST_SCRATCH; // RL6
            ctrl_ff <= RST_CTRL; // RL6
            seed_ff <= RST_SEED; // RL2
            poly_ff <= RST_POLY; // RL4
            rdata_ff <= '0;
        end else begin
            data_ff <= nxt_data;
            rdata_ff <= nxt_rdata;
            if (wr_scratch) begin
                scratch_ff <= wdata_in[SCRATCH_W-1:0]; // RL6
            end
            if (wr_ctrl) begin
                ctrl_ff <= ctrl_wfield; // RL8 RL9 RL10
            end
            if (wr_seed) begin
                seed_ff <= wdata_in; // RL1
            end
            if (wr_poly) begin
                poly_ff <= wdata_in; // RL3
            end
        end
    end

    assign rdata_out = rdata_ff;

    // helper state for the checks: has software touched seed or polynomial yet
    logic seed_touched_ff;
    logic poly_touched_ff;
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            seed_touched_ff <= 1'b0;
            poly_touched_ff <= 1'b0;
        end else begin
            seed_touched_ff <= seed_touched_ff || wr_seed;
            poly_touched_ff <= poly_touched_ff || wr_poly;
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!resetn_in);

    sequence s_seed_write;
        wr_in && addr_in == OFF_SEED;
    endsequence

    sequence s_poly_write;
        wr_in && addr_in == OFF_POLY;
    endsequence

    sequence s_reset_write;
        wr_in && addr_in == OFF_CTRL && wdata_in[CTRL_RESET_BIT];
    endsequence

    sequence s_data_write_narrow;
        wr_in && addr_in == OFF_DATA && (size_sel == SIZE_8 || size_sel == SIZE_7);
    endsequence

    sequence s_read_at(logic [ADDR_W-1:0] off);
        rd_in && addr_in == off;
    endsequence

    sequence s_quiet_data;
        !wr_in || (addr_in != OFF_DATA && addr_in != OFF_CTRL);
    endsequence

    seed_write_a: assert property (s_seed_write |=> seed_ff == $past(wdata_in)) // RL1
        else $error("seed register did not take the written value");

    seed_readback_a: assert property (s_read_at(OFF_SEED) |=> rdata_out == $past(seed_ff)) // RL1
        else $error("seed readback does not match the stored seed");

    seed_reset_a: assert property (!seed_touched_ff |-> seed_ff == RST_SEED) // RL2
        else $error("seed register lost its reset value before any write");

    poly_write_a: assert property (s_poly_write |=> poly_ff == $past(wdata_in) ##1 poly_touched_ff) // RL3
        else $error("polynomial register did not take the written value");

    poly_reset_a: assert property (!poly_touched_ff && rd_in && addr_in == OFF_POLY |=> rdata_out == RST_POLY) // RL4
        else $error("polynomial register does not read its reset value");

    // zero state and a lone one in the lowest input bit must hand back the masked polynomial itself
    poly_used_a: assert property (wr_in && addr_in == OFF_DATA && data_ff == '0 && rev_in_sel == REV_NONE && // RL3
                                  wdata_in == {{(DATA_W-1){1'b0}}, 1'b1} |=>
                                  data_ff == ($past(poly_ff) & crs_width_mask(size_sel)))
        else $error("engine is not fed from the polynomial register");

    seed_load_a: assert property (s_reset_write |=> data_ff == ($past(seed_ff) & crs_width_mask(size_sel))) // RL7
        else $error("reset bit did not load the data register from the seed");

    reset_selfclear_a: assert property (s_reset_write ##[1:4] s_read_at(OFF_CTRL) |=> !rdata_out[CTRL_RESET_BIT]) // RL7
        else $error("reset bit did not clear itself");

    data_hold_a: assert property (s_quiet_data |=> $stable(data_ff)) // RL6
        else $error("data register changed without a data or reset write");

    scratch_read_a: assert property (s_read_at(OFF_SCRATCH) |=> (rdata_out & ~SCRATCH_RD_MASK) == '0 &&
                                     rdata_out[SCRATCH_W-1:0] == $past(scratch_ff)) // RL6
        else $error("scratch byte readback wrong or upper bits set");

    ctrl_fields_a: assert property (wr_in && addr_in == OFF_CTRL |=> ctrl_ff == $past(wdata_in[CTRL_HI:CTRL_LO])) // RL8
        else $error("control fields did not take the written value");

    narrow_width_a: assert property (s_data_write_narrow |=> (data_ff & ~crs_width_mask(size_sel)) == '0) // RL8
        else $error("checksum wider than the selected polynomial");

    rev_out_a: assert property (rd_in && addr_in == OFF_DATA && rev_out |=> rdata_out == crs_bit_rev32($past(data_ff))) // RL10
        else $error("data readback not bit-reversed with reverse output set");

    plain_out_a: assert property (rd_in && addr_in == OFF_DATA && !rev_out |=> rdata_out == $past(data_ff)) // RL10
        else $error("data readback altered with reverse output clear");

    ctrl_reserved_a: assert property (s_read_at(OFF_CTRL) |=> (rdata_out & ~CTRL_RD_MASK) == '0) // RL11
        else $error("reserved control bits read nonzero");

    rd_only_once_a: assert property (!rd_in |=> rdata_out == '0) // RL11
        else $error("read data present outside the cycle after a read");
endmodule

/* rtl/crs_pkg.sv */
// constants, field layout and helpers shared by the checksum register block
package crs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SCRATCH_W = 8;
    localparam int CTRL_LO = 3;
    localparam int CTRL_HI = 7;
    localparam int CTRL_W = CTRL_HI - CTRL_LO + 1;

    localparam logic [ADDR_W-1:0] OFF_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SCRATCH = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_SEED = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_POLY = 8'h14;

    localparam logic [DATA_W-1:0] RST_DATA = 32'hffffffff;
    localparam logic [DATA_W-1:0] RST_SEED = 32'hffffffff;
    localparam logic [DATA_W-1:0] RST_POLY = 32'h04c11db7;
    localparam logic [SCRATCH_W-1:0] RST_SCRATCH = 8'h00;
    localparam logic [CTRL_W-1:0] RST_CTRL = 5'h00;

    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_SIZE_LSB = 3;
    localparam int CTRL_REVIN_LSB = 5;
    localparam int CTRL_REVOUT_BIT = 7;
    localparam logic [DATA_W-1:0] CTRL_RD_MASK = 32'h000000f8;
    localparam logic [DATA_W-1:0] SCRATCH_RD_MASK = 32'h000000ff;

    localparam logic [1:0] SIZE_32 = 2'h0;
    localparam logic [1:0] SIZE_16 = 2'h1;
    localparam logic [1:0] SIZE_8 = 2'h2;
    localparam logic [1:0] SIZE_7 = 2'h3;

    localparam logic [1:0] REV_NONE = 2'h0;
    localparam logic [1:0] REV_BYTE = 2'h1;
    localparam logic [1:0] REV_HALF = 2'h2;
    localparam logic [1:0] REV_WORD = 2'h3;

    function automatic logic [DATA_W-1:0] crs_width_mask(input logic [1:0] size);
        logic [DATA_W-1:0] m;
        m = 32'hffffffff;
        unique case (size)
            SIZE_32: m = 32'hffffffff;
            SIZE_16: m = 32'h0000ffff;
            SIZE_8: m = 32'h000000ff;
            SIZE_7: m = 32'h0000007f;
        endcase
        return m;
    endfunction

    function automatic logic [4:0] crs_top_bit(input logic [1:0] size);
        logic [4:0] t;
        t = 5'h1f;
        unique case (size)
            SIZE_32: t = 5'h1f;
            SIZE_16: t = 5'h0f;
            SIZE_8: t = 5'h07;
            SIZE_7: t = 5'h06;
        endcase
        return t;
    endfunction

    function automatic logic [DATA_W-1:0] crs_bit_rev32(input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] r;
        r = '0;
        for (int i = 0; i < DATA_W; i++) begin
            r[i] = d[DATA_W-1-i];
        end
        return r;
    endfunction
endpackage

/* rtl/crs_eng_if.sv */
// signals between the register block and the checksum engine
interface crs_eng_if;
    import crs_pkg::*;
    logic [DATA_W-1:0] crc_cur;
    logic [DATA_W-1:0] din;
    logic [DATA_W-1:0] poly;
    logic [1:0] size_sel;
    logic [1:0] rev_in_sel;
    logic [DATA_W-1:0] crc_nxt;

    modport eng (
        input crc_cur,
        input din,
        input poly,
        input size_sel,
        input rev_in_sel,
        output crc_nxt
    );

    modport regs (
        output crc_cur,
        output din,
        output poly,
        output size_sel,
        output rev_in_sel,
        input crc_nxt
    );
endinterface

/* rtl/crs_engine.sv */
// combinational checksum step over one 32-bit data word
module crs_engine
    import crs_pkg::*;
(
    crs_eng_if.eng eng
);
    function automatic logic [DATA_W-1:0] rev_in_map(input logic [DATA_W-1:0] d, input logic [1:0] mode);
        logic [DATA_W-1:0] r;
        logic [4:0] j;
        r = d;
        j = 5'h00;
        for (int i = 0; i < DATA_W; i++) begin
            j = 5'(i);
            unique case (mode)
                REV_NONE: r[i] = d[i];
                REV_BYTE: r[i] = d[{j[4:3], ~j[2:0]}];
                REV_HALF: r[i] = d[{j[4], ~j[3:0]}];
                REV_WORD: r[i] = d[~j];
            endcase
        end
        return r;
    endfunction

    // msb first, one bit per loop pass; the feedback tap follows the chosen width
    function automatic logic [DATA_W-1:0] crc_step(input logic [DATA_W-1:0] crc, input logic [DATA_W-1:0] d,
                                                   input logic [DATA_W-1:0] poly, input logic [1:0] size);
        logic [DATA_W-1:0] c;
        logic [4:0] t;
        logic fb;
        c = crc;
        t = crs_top_bit(size);
        fb = 1'b0;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            fb = c[t] ^ d[i];
            c = {c[DATA_W-2:0], 1'b0};
            if (fb) begin
                c = c ^ poly;
            end
        end
        return c & crs_width_mask(size);
    endfunction

    wire [DATA_W-1:0] din_ordered = rev_in_map(eng.din, eng.rev_in_sel); // RL9
    wire [DATA_W-1:0] poly_used = eng.poly & crs_width_mask(eng.size_sel); // RL3 RL5

    assign eng.crc_nxt = crc_step(eng.crc_cur, din_ordered, poly_used, eng.size_sel); // RL3 RL8
endmodule

/* verif/crs_seed_poly_regs_bench.sv */
// self-checking bench for the checksum register block
module crs_seed_poly_regs_bench
    import crs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    int mismatches = 0;
    int n_checks = 0;
    logic [31:0] seed_v;

    crs_seed_poly_regs uut (
        .ref_clk_in(clk),
        .resetn_in(resetn),
        .addr_in(addr),
        .wdata_in(wdata),
        .wr_in(wr),
        .rd_in(rd),
        .rdata_out(rdata)
    );

    always #5 clk = ~clk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // data stand only in the cycle after the read edge, so sample just past it
    task automatic bus_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask

    function automatic logic [31:0] wmask(input logic [1:0] sz);
        return (sz == 2'h0) ? 32'hffffffff : (sz == 2'h1) ? 32'h0000ffff : (sz == 2'h2) ? 32'h000000ff : 32'h0000007f;
    endfunction

    function automatic logic [31:0] rev_grp(input logic [31:0] d, input logic [1:0] m);
        logic [31:0] r;
        int g;
        g = (m == 2'h1) ? 8 : (m == 2'h2) ? 16 : 32;
        r = d;
        if (m != 2'h0) begin
            for (int i = 0; i < 32; i++) begin
                r[i] = d[(i / g) * g + g - 1 - (i % g)];
            end
        end
        return r;
    endfunction

    // msb-first bitwise step; the top bit position follows the selected width
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d, input logic [31:0] p,
                                             input logic [1:0] sz);
        logic [31:0] m;
        logic fb;
        int top;
        m = wmask(sz);
        top = (sz == 2'h0) ? 31 : (sz == 2'h1) ? 15 : (sz == 2'h2) ? 7 : 6;
        c = c & m;
        for (int i = 31; i >= 0; i--) begin
            fb = c[top] ^ d[i];
            c = (c << 1) & m;
            if (fb) begin
                c = c ^ (p & m);
            end
        end
        return c;
    endfunction

    task automatic t_reset_values();
        bus_rd("data", OFF_DATA, 32'hffffffff);
        bus_rd("scratch", OFF_SCRATCH, 32'h0);
        bus_rd("control", OFF_CTRL, 32'h0);
        bus_rd("seed", OFF_SEED, 32'hffffffff);
        bus_rd("unmapped", 8'h0c, 32'h0);
        bus_rd("poly", OFF_POLY, 32'h04c11db7);
        @(posedge clk);
        #1;
        chk("idle rdata", 32'h0, rdata);
        $display("test reset_values done");
    endtask

    task automatic t_seed_poly();
        bus_wr(OFF_SEED, 32'h12345678);
        bus_rd("seed", OFF_SEED, 32'h12345678);
        bus_wr(OFF_SEED, 32'h00000000);
        bus_rd("seed zero", OFF_SEED, 32'h0);
        bus_wr(OFF_POLY, 32'h1edc6f41);
        bus_wr(8'h18, 32'hdeadbeef);
        bus_rd("poly", OFF_POLY, 32'h1edc6f41);
        $display("test seed_poly done");
    endtask

    // a second reset in mid-run must bring back the seed, polynomial and scratch reset values
    task automatic t_mid_reset();
        bus_wr(OFF_SCRATCH, 32'h000000a5);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        bus_rd("seed after reset", OFF_SEED, 32'hffffffff);
        bus_rd("poly after reset", OFF_POLY, 32'h04c11db7);
        bus_rd("scratch after reset", OFF_SCRATCH, 32'h0);
        $display("test mid_reset done");
    endtask

    task automatic t_ctrl_scratch();
        bus_wr(OFF_CTRL, 32'hffffffff);
        bus_rd("control reserved", OFF_CTRL, 32'h000000f8);
        bus_wr(OFF_CTRL, 32'h0);
        bus_wr(OFF_SCRATCH, 32'hffffffff);
        bus_rd("scratch", OFF_SCRATCH, 32'h000000ff);
        bus_wr(OFF_SCRATCH, 32'h0000005a);
        bus_rd("scratch 5a", OFF_SCRATCH, 32'h0000005a);
        $display("test ctrl_scratch done");
    endtask

    task automatic t_sizes();
        seed_v = 32'h89abcdef;
        bus_wr(OFF_SEED, seed_v);
        for (int s = 0; s < 4; s++) begin
            bus_wr(OFF_CTRL, {27'h0, s[1:0], 3'b001});
            bus_rd("reloaded data", OFF_DATA, seed_v & wmask(s[1:0]));
            bus_rd("control size", OFF_CTRL, {27'h0, s[1:0], 3'b000});
        end
        $display("test sizes done");
    endtask

    task automatic t_rev_out();
        bus_wr(OFF_CTRL, 32'h00000081);
        bus_rd("reversed data", OFF_DATA, rev_grp(seed_v, 2'h3));
        bus_wr(OFF_CTRL, 32'h0);
        bus_rd("plain data", OFF_DATA, seed_v);
        $display("test rev_out done");
    endtask

    task automatic t_data_step();
        logic [31:0] w;
        logic [31:0] p;
        w = 32'hc3a51e07;
        p = 32'h04c11db7;
        bus_wr(OFF_POLY, p);
        for (int m = 0; m < 4; m++) begin
            bus_wr(OFF_CTRL, {25'h0, m[1:0], m[1:0], 3'b001});
            bus_wr(OFF_DATA, w);
            bus_rd("checksum", OFF_DATA, crc_step(seed_v, rev_grp(w, m[1:0]), p, m[1:0]));
        end
        bus_wr(OFF_CTRL, 32'h00000001);
        bus_wr(OFF_POLY, 32'h1edc6f41);
        bus_wr(OFF_DATA, w);
        bus_rd("checksum new poly", OFF_DATA, crc_step(seed_v, w, 32'h1edc6f41, 2'h0));
        bus_wr(OFF_POLY, 32'h00001021);
        bus_wr(OFF_CTRL, 32'h00000009);
        bus_wr(OFF_DATA, w);
        bus_rd("checksum 16 bit", OFF_DATA, crc_step(seed_v, w, 32'h00001021, 2'h1));
        bus_wr(OFF_SEED, 32'h0);
        bus_wr(OFF_CTRL, 32'h00000001);
        bus_wr(OFF_DATA, 32'h00000001);
        bus_rd("checksum unit word", OFF_DATA, 32'h00001021);
        $display("test data_step done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // the whole sequence needs well under 2000 cycles
    initial begin
        #100us;
        mismatches++;
        complete_run();
    end

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_reset_values();
        t_seed_poly();
        t_mid_reset();
        t_ctrl_scratch();
        t_sizes();
        t_rev_out();
        t_data_step();
        complete_run();
    end
endmodule
